/* File: pkg/prescaler_pkg.sv */
// Constants shared by the timer prescaler block and its testbench; the count synchroniser uses none of them.
package prescaler_pkg;

  // ==========================================================================
  // Register map, one aligned 32-bit word per register
  localparam logic [7:0] SFR_OFFSET = 8'h00;
  localparam logic [7:0] CS_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // ==========================================================================
  // Special function register fields and reset value
  localparam int SYNC_HOLD_BIT = 7;
  localparam int OTHER_PSR_BIT = 1;
  localparam int SHARED_PSR_BIT = 0;
  localparam logic [7:0] SFR_RESET = 8'h00;

  // ==========================================================================
  // Clock select register fields and reset value
  localparam int CS_W = 3;
  localparam int CS0_LSB = 0;
  localparam int CS1_LSB = 4;
  localparam int CS3_LSB = 8;
  localparam logic [11:0] CS_RESET = 12'h000;

  // ==========================================================================
  // Clock select codes; the third timer reuses the two external codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [2:0] CS_DIV16 = 3'h6;
  localparam logic [2:0] CS_DIV32 = 3'h7;

  // ==========================================================================
  // Prescaler width; tap of divisor 2**k fires when the low k bits are all one
  localparam int PRE_W = 10;
  localparam int TAP8_BITS = 3;
  localparam int TAP16_BITS = 4;
  localparam int TAP32_BITS = 5;
  localparam int TAP64_BITS = 6;
  localparam int TAP256_BITS = 8;
  localparam int TAP1024_BITS = 10;

endpackage

/* File: hdl/ext_count_sync.sv */
// Count pin synchroniser and edge detector for one externally clocked timer.
`timescale 1ns/1ns
`default_nettype none

module ext_count_sync (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic latch_q;
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic agree;

  // ==========================================================================
  // Sampling stages
  // The latch is open while the clock is high, so the pin is caught half a
  // cycle before the first register and is read by that register alone.
  always_latch
  begin
    if (clk_sys_i)
    begin
      latch_q = pin_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    s1_q <= latch_q;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // ==========================================================================
  // Edge detection
  // A level is accepted only once two stages agree, which rejects a single
  // sample caught mid-transition.
  assign agree = (s2_q == s3_q);

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      level_q <= 1'b0;
    end
    else if (agree)
    begin
      level_q <= s3_q;
    end
  end

  assign rise_o = agree && s3_q && !level_q;
  assign fall_o = agree && !s3_q && level_q;

  a_rise_once: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rise_o |=> !rise_o && !fall_o)
    else $error("count pin rise pulse lasted more than one cycle");

  a_rise_cause: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (s2_q && !s3_q && !level_q) |=> rise_o)
    else $error("accepted high level gave no rise pulse");

  // A high level caught by the first register is accepted two cycles later.
  a_pin_latency: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (s1_q && !s2_q && !s3_q && !level_q) |-> ##2 rise_o)
    else $error("count pin rise took too long to reach the edge detector");

endmodule

`default_nettype wire

/* File: hdl/timer_prescaler.sv */
// Shared timer prescaler with per-timer clock select and count pin edge logic.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

module timer_prescaler (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_count_pin0_i,
  input wire logic ext_count_pin1_i,
  output logic timer0_tick_o,
  output logic timer1_tick_o,
  output logic timer3_tick_o,
  output logic other_prescaler_reset_o
);

  // ==========================================================================
  // Tick selection
  // Taps are ordered {1024, 256, 64, 32, 16, 8}. The third timer has no
  // external input and uses the top two codes for the extra taps instead.
  function automatic logic pick_tick(
    input logic [2:0] sel,
    input logic [5:0] taps,
    input logic third,
    input logic rise,
    input logic fall
  );
    logic t;
    t = 1'b0;
    unique case (sel)
      prescaler_pkg::CS_STOP: t = 1'b0;
      prescaler_pkg::CS_DIRECT: t = 1'b1;
      prescaler_pkg::CS_DIV8: t = taps[0];
      prescaler_pkg::CS_DIV64: t = taps[3];
      prescaler_pkg::CS_DIV256: t = taps[4];
      prescaler_pkg::CS_DIV1024: t = taps[5];
      prescaler_pkg::CS_EXT_FALL: t = third ? taps[1] : fall;
      prescaler_pkg::CS_EXT_RISE: t = third ? taps[2] : rise;
    endcase
    return t;
  endfunction

  // ==========================================================================
  // Registers and bus decode
  logic [7:0] sfr_q;
  logic [11:0] cs_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [prescaler_pkg::PRE_W-1:0] pre_q;
  logic [2:0] tick_q;
  logic other_psr_q;

  logic req;
  logic hit_sfr;
  logic hit_cs;
  logic hit_status;
  logic wr_sfr;
  logic wr_cs_lo;
  logic wr_cs_hi;
  logic sync_hold;
  logic shared_psr;
  logic other_psr;
  logic [31:0] rdat_d;
  logic [11:0] cs_d;
  logic [7:0] sfr_d;
  logic [5:0] taps;
  logic [2:0] ext_rise;
  logic [2:0] ext_fall;
  logic [2:0] tick_d;
  logic pin0_rise;
  logic pin0_fall;
  logic pin1_rise;
  logic pin1_fall;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign hit_sfr = (wb_adr_i == prescaler_pkg::SFR_OFFSET);
  assign hit_cs = (wb_adr_i == prescaler_pkg::CS_OFFSET);
  assign hit_status = (wb_adr_i == prescaler_pkg::STATUS_OFFSET);
  assign wr_sfr = req && wb_we_i && hit_sfr && wb_sel_i[0];
  assign wr_cs_lo = req && wb_we_i && hit_cs && wb_sel_i[0];
  assign wr_cs_hi = req && wb_we_i && hit_cs && wb_sel_i[1];

  assign sync_hold = sfr_q[prescaler_pkg::SYNC_HOLD_BIT];
  assign shared_psr = sfr_q[prescaler_pkg::SHARED_PSR_BIT];
  assign other_psr = sfr_q[prescaler_pkg::OTHER_PSR_BIT];

  // ==========================================================================
  // Special function register update
  // A written reset bit lives for one cycle and then drops unless hold mode
  // is on; a write that turns hold mode off drops both bits at once.
  always_comb
  begin
    sfr_d = sfr_q;
    if (wr_sfr)
    begin
      sfr_d = wb_dat_i[7:0];
      if (sync_hold && !wb_dat_i[prescaler_pkg::SYNC_HOLD_BIT])
      begin
        sfr_d[prescaler_pkg::SHARED_PSR_BIT] = 1'b0;
        sfr_d[prescaler_pkg::OTHER_PSR_BIT] = 1'b0;
      end
    end
    else if (!sync_hold)
    begin
      sfr_d[prescaler_pkg::SHARED_PSR_BIT] = 1'b0;
      sfr_d[prescaler_pkg::OTHER_PSR_BIT] = 1'b0;
    end
  end

  always_comb
  begin
    cs_d = cs_q;
    if (wr_cs_lo)
    begin
      cs_d[7:0] = wb_dat_i[7:0];
    end
    if (wr_cs_hi)
    begin
      cs_d[11:8] = wb_dat_i[11:8];
    end
    cs_d[3] = 1'b0;
    cs_d[7] = 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      sfr_q <= prescaler_pkg::SFR_RESET;
      cs_q <= prescaler_pkg::CS_RESET;
    end
    else
    begin
      sfr_q <= sfr_d;
      cs_q <= cs_d;
    end
  end

  // ==========================================================================
  // Wishbone answer: one wait state, unmapped addresses read zero
  always_comb
  begin
    rdat_d = 32'h0000_0000;
    if (hit_sfr)
    begin
      rdat_d[7:0] = sfr_q;
    end
    else if (hit_cs)
    begin
      rdat_d[11:0] = cs_q;
    end
    else if (hit_status)
    begin
      rdat_d[prescaler_pkg::PRE_W-1:0] = pre_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      rdat_q <= req ? rdat_d : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // Shared prescaler
  // The counter ignores every select field, so a timer enabled on a tap of
  // divisor N sees its first tick after 1 to N cycles plus the output flop.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || shared_psr)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign taps[0] = &pre_q[prescaler_pkg::TAP8_BITS-1:0];
  assign taps[1] = &pre_q[prescaler_pkg::TAP16_BITS-1:0];
  assign taps[2] = &pre_q[prescaler_pkg::TAP32_BITS-1:0];
  assign taps[3] = &pre_q[prescaler_pkg::TAP64_BITS-1:0];
  assign taps[4] = &pre_q[prescaler_pkg::TAP256_BITS-1:0];
  assign taps[5] = &pre_q[prescaler_pkg::TAP1024_BITS-1:0];

  // ==========================================================================
  // External count pins, first two timers only
  // Each pin has its own synchroniser; software must switch to or from an
  // external code only while the pin is steady, or one false tick may appear.
  ext_count_sync u_pin0_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(ext_count_pin0_i),
    .rise_o(pin0_rise),
    .fall_o(pin0_fall)
  );

  ext_count_sync u_pin1_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(ext_count_pin1_i),
    .rise_o(pin1_rise),
    .fall_o(pin1_fall)
  );

  assign ext_rise = {1'b0, pin1_rise, pin0_rise};
  assign ext_fall = {1'b0, pin1_fall, pin0_fall};

  // ==========================================================================
  // Per-timer tick enables
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tick
      assign tick_d[gi] = pick_tick(cs_q[gi*4 +: prescaler_pkg::CS_W], taps,
        (gi == 2), ext_rise[gi], ext_fall[gi]);
    end
  endgenerate

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      tick_q <= 3'h0;
      other_psr_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_d;
      other_psr_q <= other_psr;
    end
  end

  assign timer0_tick_o = tick_q[0];
  assign timer1_tick_o = tick_q[1];
  assign timer3_tick_o = tick_q[2];
  assign other_prescaler_reset_o = other_psr_q;

  // ==========================================================================
  // Checks
  a_psr_autoclear: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (shared_psr && !sync_hold && !wr_sfr) |=> !shared_psr)
    else $error("shared prescaler reset bit did not self clear");

  a_hold_keeps_psr: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (sync_hold && shared_psr && other_psr && !wr_sfr) |=> shared_psr && other_psr)
    else $error("reset bits dropped while hold mode was set");

  a_hold_release: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (sync_hold && wr_sfr && !wb_dat_i[prescaler_pkg::SYNC_HOLD_BIT])
      |=> !shared_psr && !other_psr ##2 !other_prescaler_reset_o)
    else $error("leaving hold mode did not clear the reset bits");

  a_pre_held_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    shared_psr |=> (pre_q == '0) && (tick_d[0] == 1'b0 || cs_q[2:0] != prescaler_pkg::CS_DIV8))
    else $error("prescaler not held at zero during its reset");

  // A reset bit written in the next cycle may stop the count, so each step is
  // judged on its own cycle rather than over a run of cycles.
  a_pre_runs: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!srst_i && !shared_psr) |=> (pre_q == 10'($past(pre_q) + 10'h001)))
    else $error("prescaler stopped while not in reset");

  a_direct_tick: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cs_q[2:0] == prescaler_pkg::CS_DIRECT && !wr_cs_lo) [*2] |=> timer0_tick_o [*2])
    else $error("direct select did not tick every cycle");

  a_div8_tick: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cs_q[6:4] == prescaler_pkg::CS_DIV8 && pre_q[2:0] == 3'h6 && !shared_psr && !wr_cs_lo)
      |=> !timer1_tick_o ##1 timer1_tick_o)
    else $error("divide by eight tick out of phase");

  a_stop_silent: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cs_q[2:0] == prescaler_pkg::CS_STOP) |=> !timer0_tick_o)
    else $error("stopped timer received a tick");

  a_third_div16: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cs_q[10:8] == prescaler_pkg::CS_DIV16 && pre_q[3:0] == 4'hf) |=> timer3_tick_o)
    else $error("third timer missed its divide by sixteen tick");

  a_ack_single: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held for more than one cycle");

endmodule

`default_nettype wire

/* File: test/ext_clk_source.sv */
// Behavioural external count clock source driving one timer count pin.
`timescale 1ns/1ns
`default_nettype none

module ext_clk_source (
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic [2:0] half_i,
  output logic pin_o,
  output logic [15:0] rises_o,
  output logic [15:0] falls_o
);
  // ==========================================================================
  // Toggle generator
  logic [2:0] cnt_q;
  logic [2:0] half_eff;

  // Half periods under two system cycles cannot be sampled, so they are widened.
  assign half_eff = (half_i < 3'h2) ? 3'h2 : half_i;

  initial
  begin
    pin_o = 1'b0;
    cnt_q = 3'h0;
    rises_o = 16'h0000;
    falls_o = 16'h0000;
  end

  // The pin holds its level while stopped, so enabling a select sees a steady pin.
  always @(posedge clk_sys_i)
  begin
    if (run_i)
    begin
      if (cnt_q + 3'h1 >= half_eff)
      begin
        cnt_q <= 3'h0;
        pin_o <= ~pin_o;
        if (pin_o)
          falls_o <= falls_o + 16'h0001;
        else
          rises_o <= rises_o + 16'h0001;
      end
      else
        cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking testbench for the shared timer prescaler block.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ==========================================================================
  // Signals
  localparam int WIN = 2048;
  logic clk_sys_i = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wr = 32'h0000_0000;
  logic [31:0] wb_rd;
  logic wb_ack;
  logic pin0, pin1, t0, t1, t3, opsr;
  logic run = 1'b0;
  logic [2:0] half = 3'h2;
  logic [15:0] rise0, fall0, rise1, fall1;
  logic [31:0] c0, c1, c3, q, s, r;
  int errors;
  int num_checks;

  always #5 clk_sys_i = ~clk_sys_i;

  timer_prescaler timer_prescaler_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wr),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .ext_count_pin0_i(pin0),
    .ext_count_pin1_i(pin1), .timer0_tick_o(t0), .timer1_tick_o(t1),
    .timer3_tick_o(t3), .other_prescaler_reset_o(opsr)
  );
  ext_clk_source src0 (.clk_sys_i(clk_sys_i), .run_i(run), .half_i(half),
    .pin_o(pin0), .rises_o(rise0), .falls_o(fall0));
  ext_clk_source src1 (.clk_sys_i(clk_sys_i), .run_i(run), .half_i(half),
    .pin_o(pin1), .rises_o(rise1), .falls_o(fall1));

  // ==========================================================================
  // Tasks and expectations
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_wr <= d;
    @(posedge clk_sys_i);
    while (wb_ack !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_sys_i);
    end
    if (n >= 20)
      check(32'h0000_0000, 32'h0000_0001);
    rd = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic window(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      c0 = c0 + {31'h0, t0};
      c1 = c1 + {31'h0, t1};
      c3 = c3 + {31'h0, t3};
    end
  endtask

  function automatic logic [31:0] exp_ticks(input logic [2:0] c, input logic third);
    case (c)
      prescaler_pkg::CS_DIRECT: return 32'(WIN);
      prescaler_pkg::CS_DIV8: return 32'(WIN / 8);
      prescaler_pkg::CS_DIV64: return 32'(WIN / 64);
      prescaler_pkg::CS_DIV256: return 32'(WIN / 256);
      prescaler_pkg::CS_DIV1024: return 32'(WIN / 1024);
      prescaler_pkg::CS_DIV16: return third ? 32'(WIN / 16) : 32'h0000_0000;
      prescaler_pkg::CS_DIV32: return third ? 32'(WIN / 32) : 32'h0000_0000;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================================
  // Watchdog
  initial
  begin
    #600000;
    errors++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    errors = 0;
    num_checks = 0;
    void'($urandom(32'h0000_99a8));
    repeat (3) @(posedge clk_sys_i);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    wb(1'b0, prescaler_pkg::SFR_OFFSET, 32'h0000_0000, q);
    check(q, {24'h00_0000, prescaler_pkg::SFR_RESET});
    wb(1'b0, prescaler_pkg::CS_OFFSET, 32'h0000_0000, q);
    check(q, {20'h0_0000, prescaler_pkg::CS_RESET});
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h0C, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    wb(1'b0, prescaler_pkg::STATUS_OFFSET, 32'h0000_0000, s);
    wb(1'b0, prescaler_pkg::STATUS_OFFSET, 32'h0000_0000, q);
    check((q - s) & 32'h0000_03FF, 32'h0000_0003);
    r = $urandom() & 32'h0000_007C;
    wb(1'b1, prescaler_pkg::SFR_OFFSET, r | 32'h0000_0003, q);
    wb(1'b0, prescaler_pkg::SFR_OFFSET, 32'h0000_0000, q);
    check(q, r);
    wb(1'b1, prescaler_pkg::CS_OFFSET, 32'h0000_0012, q);
    wb(1'b1, prescaler_pkg::SFR_OFFSET, 32'h0000_0083, q);
    wb(1'b0, prescaler_pkg::SFR_OFFSET, 32'h0000_0000, q);
    check(q, 32'h0000_0083);
    check({31'h0, opsr}, 32'h0000_0001);
    c0 = 0; c1 = 0; c3 = 0;
    window(256);
    check(c0, 32'h0000_0000);
    check(c1, 32'h0000_0100);
    wb(1'b1, prescaler_pkg::SFR_OFFSET, 32'h0000_0000, q);
    wb(1'b0, prescaler_pkg::SFR_OFFSET, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    check({31'h0, opsr}, 32'h0000_0000);
    // Every code on every timer; the count pins stand still meanwhile.
    for (int c = 0; c < 8; c++)
    begin
      s = {21'h0, 3'(c ^ 3), 1'b0, 3'(7 - c), 1'b0, 3'(c)};
      wb(1'b1, prescaler_pkg::CS_OFFSET, s, q);
      repeat (2) @(posedge clk_sys_i);
      c0 = 0; c1 = 0; c3 = 0;
      window(WIN);
      check(c0, exp_ticks(3'(c), 1'b0));
      check(c1, exp_ticks(3'(7 - c), 1'b0));
      check(c3, exp_ticks(3'(c ^ 3), 1'b1));
    end
    // Selects change only while the pins are steady.
    wb(1'b1, prescaler_pkg::CS_OFFSET, 32'h0000_0067, q);
    repeat (2) @(posedge clk_sys_i);
    half <= 3'($urandom_range(5, 2));
    s = {16'h0000, rise0};
    r = {16'h0000, fall1};
    c0 = 0; c1 = 0; c3 = 0;
    run <= 1'b1;
    window(400);
    run <= 1'b0;
    window(12);
    check(c0, {16'h0000, rise0} - s);
    check(c1, {16'h0000, fall1} - r);
    complete_run();
  end
endmodule

`default_nettype wire
